// ### rtl/dmp_defs.vh
/*
  Constants for the display memory pixel layout block: modes, window decode,
  palette size and colour field positions.
  Assumes inclusion by bare name from the rtl directory.
*/
`ifndef DMP_DEFS_VH
`define DMP_DEFS_VH

// ---------------------------------------------------------------
// Modes
// ---------------------------------------------------------------
`define DMP_MODE_PLANAR 2'h0
`define DMP_MODE_DC15 2'h1
`define DMP_MODE_DC16 2'h2
`define DMP_MODE_INDEX 2'h3

// ---------------------------------------------------------------
// CPU window and memory
// ---------------------------------------------------------------
`define DMP_WIN_BASE 20'ha0000
`define DMP_WIN_LAST 20'haffff
`define DMP_WIN_TOP4 4'ha
`define DMP_WIN_BITS 16
`define DMP_PLANES 4
`define DMP_PIX_PER_BYTE 8
`define DMP_PAGE_BITS 4
`define DMP_LUT_ENTRIES 256
`define DMP_MAX_DC_W 800
`define DMP_MAX_DC_H 600

// ---------------------------------------------------------------
// Direct colour fields
// ---------------------------------------------------------------
`define DMP_R555_LSB 10
`define DMP_G555_LSB 5
`define DMP_R565_LSB 11
`define DMP_G565_LSB 5

`endif

// ### rtl/dmp_palette.v
/*
  Palette lookup table: 256 entries of 24-bit colour, one write port,
  one registered read port addressed by the pixel value.
  Assumes the loader and the refresh path share the one clock.
*/
`timescale 1ns/1ps

module dmp_palette #(
  parameter ENTRIES = 256,
  parameter AW = 8
) (
  clk,
  wr_en,
  wr_index,
  wr_color,
  rd_index,
  rd_color
);
  input wire clk;
  input wire wr_en;
  input wire [AW-1:0] wr_index;
  input wire [23:0] wr_color;
  input wire [AW-1:0] rd_index;
  output reg [23:0] rd_color;

  reg [23:0] lut_mem [0:ENTRIES-1];

  always @(posedge clk) begin
    if (wr_en) begin
      lut_mem[wr_index] <= wr_color;
    end
    rd_color <= lut_mem[rd_index];
  end
endmodule // dmp_palette

// ### rtl/dmp_pixel_layout.v
/*
  Display memory pixel layout: maps CPU window accesses onto four display
  planes, maps refresh fetches onto pixel colour for the DAC.
  Assumes single-cycle synchronous display memory owned by this block, a CPU
  that sets mode, plane select and page before each access, and a refresh
  engine that walks pixel addresses and presents one fetch per cycle.
*/
`timescale 1ns/1ps
`include "dmp_defs.vh"

module dmp_pixel_layout #(
  parameter PAGE_BITS = `DMP_PAGE_BITS
) (
  clk,
  reset,
  mode,
  plane_wr_mask,
  plane_rd_sel,
  page_sel,
  cpu_addr,
  cpu_wr,
  cpu_rd,
  cpu_wdata,
  cpu_rdata,
  cpu_rvalid,
  lut_wr,
  lut_index,
  lut_color,
  pix_req,
  pix_addr,
  pix_bit,
  dac_red,
  dac_green,
  dac_blue,
  dac_valid
);
  // MA spans every byte of all four planes; each plane holds a quarter of it
  localparam MA = `DMP_WIN_BITS + PAGE_BITS;
  localparam PA = MA - 2;
  localparam DEPTH = 1 << PA;

  input wire clk;
  input wire reset;
  input wire [1:0] mode;
  input wire [3:0] plane_wr_mask;
  input wire [1:0] plane_rd_sel;
  input wire [PAGE_BITS-1:0] page_sel;
  input wire [19:0] cpu_addr;
  input wire cpu_wr;
  input wire cpu_rd;
  input wire [7:0] cpu_wdata;
  output reg [7:0] cpu_rdata;
  output reg cpu_rvalid;
  input wire lut_wr;
  input wire [7:0] lut_index;
  input wire [23:0] lut_color;
  input wire pix_req;
  input wire [MA-2:0] pix_addr;
  input wire [2:0] pix_bit;
  output reg [7:0] dac_red;
  output reg [7:0] dac_green;
  output reg [7:0] dac_blue;
  output reg dac_valid;

  // ---------------------------------------------------------------
  // Display planes
  // ---------------------------------------------------------------
  reg [7:0] plane0 [0:DEPTH-1];
  reg [7:0] plane1 [0:DEPTH-1];
  reg [7:0] plane2 [0:DEPTH-1];
  reg [7:0] plane3 [0:DEPTH-1];

  // Expand 5 or 6 bits to the 8-bit DAC by repeating the top bits
  function [7:0] exp5;
    input [4:0] v;
    begin
      exp5 = {v, v[4:2]};
    end
  endfunction

  function [7:0] exp6;
    input [5:0] v;
    begin
      exp6 = {v, v[5:4]};
    end
  endfunction

  // ---------------------------------------------------------------
  // CPU window decode
  // ---------------------------------------------------------------
  wire cpu_hit;
  wire [MA-1:0] cpu_lin;
  wire packed_mode;

  assign cpu_hit = (cpu_addr[19:16] == `DMP_WIN_TOP4);
  assign cpu_lin = {page_sel, cpu_addr[15:0]};
  assign packed_mode = (mode == `DMP_MODE_DC15) || (mode == `DMP_MODE_DC16);

  // Packed modes interleave sequential bytes over the planes
  wire [1:0] cpu_pk_plane;
  wire [PA-1:0] cpu_pk_off;
  wire [PA-1:0] cpu_pl_off;
  assign cpu_pk_plane = cpu_lin[1:0];
  assign cpu_pk_off = cpu_lin[MA-1:2];
  // Planar mode uses only the low page bits, a plane being a quarter of memory
  assign cpu_pl_off = cpu_lin[PA-1:0];

  always @(posedge clk) begin
    if (cpu_hit && cpu_wr) begin
      if (packed_mode || mode == `DMP_MODE_INDEX) begin
        case (cpu_pk_plane)
          2'h0: plane0[cpu_pk_off] <= cpu_wdata;
          2'h1: plane1[cpu_pk_off] <= cpu_wdata;
          2'h2: plane2[cpu_pk_off] <= cpu_wdata;
          default: plane3[cpu_pk_off] <= cpu_wdata;
        endcase
      end else begin
        // Same byte offset in every enabled plane
        if (plane_wr_mask[0]) plane0[cpu_pl_off] <= cpu_wdata;
        if (plane_wr_mask[1]) plane1[cpu_pl_off] <= cpu_wdata;
        if (plane_wr_mask[2]) plane2[cpu_pl_off] <= cpu_wdata;
        if (plane_wr_mask[3]) plane3[cpu_pl_off] <= cpu_wdata;
      end
    end
  end

  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    if (packed_mode || mode == `DMP_MODE_INDEX) begin
      case (cpu_pk_plane)
        2'h0: rd_byte = plane0[cpu_pk_off];
        2'h1: rd_byte = plane1[cpu_pk_off];
        2'h2: rd_byte = plane2[cpu_pk_off];
        default: rd_byte = plane3[cpu_pk_off];
      endcase
    end else begin
      case (plane_rd_sel)
        2'h0: rd_byte = plane0[cpu_pl_off];
        2'h1: rd_byte = plane1[cpu_pl_off];
        2'h2: rd_byte = plane2[cpu_pl_off];
        default: rd_byte = plane3[cpu_pl_off];
      endcase
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      cpu_rdata <= 8'h00;
      cpu_rvalid <= 1'b0;
    end else begin
      cpu_rvalid <= cpu_hit && cpu_rd;
      cpu_rdata <= (cpu_hit && cpu_rd) ? rd_byte : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Refresh fetch, stage 1
  // ---------------------------------------------------------------
  // pix_addr is a plane byte offset in planar mode, a pixel index otherwise
  wire [PA-1:0] pl_off;
  wire [PA-1:0] ix_off;
  wire [PA-1:0] dc_off;
  wire [1:0] ix_plane;
  wire dc_hi;
  assign pl_off = pix_addr[PA-1:0];
  assign ix_off = {1'b0, pix_addr[MA-2:2]};
  assign ix_plane = pix_addr[1:0];
  assign dc_off = pix_addr[MA-2:1];
  assign dc_hi = pix_addr[0];

  reg [15:0] f_word;
  reg [3:0] f_nib;
  reg [7:0] f_idx;
  always @* begin
    // Planar pixel: one bit per plane, bit 7 is the leftmost pixel
    f_nib = {plane3[pl_off][3'h7 - pix_bit], plane2[pl_off][3'h7 - pix_bit],
      plane1[pl_off][3'h7 - pix_bit], plane0[pl_off][3'h7 - pix_bit]};
    case (ix_plane)
      2'h0: f_idx = plane0[ix_off];
      2'h1: f_idx = plane1[ix_off];
      2'h2: f_idx = plane2[ix_off];
      default: f_idx = plane3[ix_off];
    endcase
    // Two sequential bytes, low byte first, as the CPU wrote them
    if (dc_hi) begin
      f_word = {plane3[dc_off], plane2[dc_off]};
    end else begin
      f_word = {plane1[dc_off], plane0[dc_off]};
    end
  end

  reg [1:0] s1_mode_reg;
  reg s1_valid_reg;
  reg [15:0] s1_word_reg;
  wire [7:0] lut_rd_index;
  wire [23:0] lut_rd_color;
  assign lut_rd_index = (mode == `DMP_MODE_PLANAR) ? {4'h0, f_nib} : f_idx;

  always @(posedge clk) begin
    if (reset) begin
      s1_mode_reg <= `DMP_MODE_PLANAR;
      s1_valid_reg <= 1'b0;
      s1_word_reg <= 16'h0000;
    end else begin
      s1_mode_reg <= mode;
      s1_valid_reg <= pix_req;
      s1_word_reg <= f_word;
    end
  end

  dmp_palette #(
    .ENTRIES(`DMP_LUT_ENTRIES),
    .AW(8)
  ) u_palette (
    .clk(clk),
    .wr_en(lut_wr),
    .wr_index(lut_index),
    .wr_color(lut_color),
    .rd_index(lut_rd_index),
    .rd_color(lut_rd_color)
  );

  // ---------------------------------------------------------------
  // Colour out, stage 2
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      dac_red <= 8'h00;
      dac_green <= 8'h00;
      dac_blue <= 8'h00;
      dac_valid <= 1'b0;
    end else begin
      dac_valid <= s1_valid_reg;
      case (s1_mode_reg)
        `DMP_MODE_DC15: begin
          // Bit 15 ignored
          dac_red <= exp5(s1_word_reg[`DMP_R555_LSB+4:`DMP_R555_LSB]);
          dac_green <= exp5(s1_word_reg[`DMP_G555_LSB+4:`DMP_G555_LSB]);
          dac_blue <= exp5(s1_word_reg[4:0]);
        end
        `DMP_MODE_DC16: begin
          dac_red <= exp5(s1_word_reg[`DMP_R565_LSB+4:`DMP_R565_LSB]);
          dac_green <= exp6(s1_word_reg[`DMP_G565_LSB+5:`DMP_G565_LSB]);
          dac_blue <= exp5(s1_word_reg[4:0]);
        end
        default: begin
          dac_red <= lut_rd_color[23:16];
          dac_green <= lut_rd_color[15:8];
          dac_blue <= lut_rd_color[7:0];
        end
      endcase
    end
  end
  // Four page bits reach all 1M bytes, enough for an 800x600 direct colour frame
endmodule // dmp_pixel_layout

// ### bench/dmp_pixel_layout_props.sv
/*
  Checker for dmp_pixel_layout: read and fetch timing, idle read data, colour expansion.
  Assumes mode is held steady from a fetch request until its colour appears.
*/
`timescale 1ns/1ps
`include "dmp_defs.vh"
module dmp_pixel_layout_props (
  input wire clk,
  input wire reset,
  input wire [1:0] mode,
  input wire [19:0] cpu_addr,
  input wire cpu_rd,
  input wire [7:0] cpu_rdata,
  input wire cpu_rvalid,
  input wire pix_req,
  input wire [7:0] dac_red,
  input wire [7:0] dac_green,
  input wire dac_valid
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_rd_win;
    cpu_rd && cpu_addr[19:16] == 4'ha;
  endsequence
  sequence s_fetch;
    pix_req ##2 dac_valid;
  endsequence
  property p_rd_ans;
    s_rd_win |=> cpu_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("window read not answered");
  property p_rd_out;
    cpu_rd && cpu_addr[19:16] != 4'ha |=> !cpu_rvalid;
  endproperty
  a_rd_out: assert property (p_rd_out) else $error("read outside window answered");
  property p_rv_cause;
    cpu_rvalid |-> $past(cpu_rd) && $past(cpu_addr[19:16]) == 4'ha;
  endproperty
  a_rv_cause: assert property (p_rv_cause) else $error("read data without a read");
  property p_idle;
    !cpu_rvalid |-> cpu_rdata == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("read data not zero when idle");
  property p_fetch;
    pix_req |-> s_fetch;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch not answered in two cycles");
  property p_dv_cause;
    dac_valid |-> $past(pix_req, 2);
  endproperty
  a_dv_cause: assert property (p_dv_cause) else $error("colour without a fetch");
  property p_dc15;
    dac_valid && $past(mode, 2) == `DMP_MODE_DC15
      |-> dac_red[2:0] == dac_red[7:5] && dac_green[2:0] == dac_green[7:5];
  endproperty
  a_dc15: assert property (p_dc15) else $error("5-5-5 expansion wrong");
  property p_dc16;
    dac_valid && $past(mode, 2) == `DMP_MODE_DC16
      |-> dac_green[1:0] == dac_green[7:6] && dac_red[2:0] == dac_red[7:5];
  endproperty
  a_dc16: assert property (p_dc16) else $error("5-6-5 expansion wrong");
endmodule // dmp_pixel_layout_props

bind dmp_pixel_layout dmp_pixel_layout_props u_props (
  .clk(clk), .reset(reset), .mode(mode), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd),
  .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .pix_req(pix_req),
  .dac_red(dac_red), .dac_green(dac_green), .dac_valid(dac_valid)
);

// ### bench/dmp_host_cpu.sv
/*
  Host CPU model: byte writes and reads through the display memory window.
  Assumes the bench sets mode, plane selects and page before each access.
*/
`timescale 1ns/1ps
module dmp_host_cpu (
  input wire clk,
  input wire [7:0] cpu_rdata,
  input wire cpu_rvalid,
  output logic [19:0] cpu_addr = 20'h00000,
  output logic cpu_wr = 1'b0,
  output logic cpu_rd = 1'b0,
  output logic [7:0] cpu_wdata = 8'h00
);
  // ----------------------------------------
  // Accesses
  // ----------------------------------------
  // Released lines flip so a stale value never passes for fresh data
  task automatic release_bus();
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_addr = ~cpu_addr;
    cpu_wdata = ~cpu_wdata;
  endtask
  task automatic write_byte(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(posedge clk);
    #1;
    release_bus();
  endtask
  task automatic read_byte(input logic [19:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk);
    #1;
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(posedge clk);
    #1;
    d = cpu_rdata;
    ok = cpu_rvalid;
    release_bus();
  endtask
endmodule // dmp_host_cpu

// ### bench/dmp_pixel_layout_test.sv
/*
  Self-checking bench for dmp_pixel_layout: planar, window, paging, direct and indexed colour.
  Assumes the host model in dmp_host_cpu and the bound checker.
*/
`timescale 1ns/1ps
`include "dmp_defs.vh"
module dmp_pixel_layout_test;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] mode = 2'h0;
  logic [3:0] plane_wr_mask = 4'hf;
  logic [1:0] plane_rd_sel = 2'h0;
  logic [3:0] page_sel = 4'h0;
  logic lut_wr = 1'b0;
  logic [7:0] lut_index = 8'h00;
  logic [23:0] lut_color = 24'h000000;
  logic pix_req = 1'b0;
  logic [18:0] pix_addr = 19'h00000;
  logic [2:0] pix_bit = 3'h0;
  logic [7:0] d [4];
  logic [7:0] got;
  logic ok;
  wire [19:0] cpu_addr;
  wire cpu_wr, cpu_rd, cpu_rvalid, dac_valid;
  wire [7:0] cpu_wdata, cpu_rdata, dac_red, dac_green, dac_blue;
  int mismatches = 0;
  int checked = 0;
  dmp_pixel_layout dut (.clk(clk), .reset(reset), .mode(mode), .plane_wr_mask(plane_wr_mask),
    .plane_rd_sel(plane_rd_sel), .page_sel(page_sel), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
    .lut_wr(lut_wr), .lut_index(lut_index), .lut_color(lut_color), .pix_req(pix_req),
    .pix_addr(pix_addr), .pix_bit(pix_bit), .dac_red(dac_red), .dac_green(dac_green),
    .dac_blue(dac_blue), .dac_valid(dac_valid));
  dmp_host_cpu host (.clk(clk), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
    .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial forever #2.5 clk = ~clk;
  task automatic end_of_test();
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t byte %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_rgb(input logic [23:0] g, input logic [23:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t colour %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic [23:0] pal(input logic [7:0] i);
    return {i[3:0], 4'h0, 8'ha5 ^ i, i};
  endfunction
  function automatic logic [23:0] dc(input logic [1:0] m, input logic [15:0] p);
    if (m == `DMP_MODE_DC15) return {p[14:10], p[14:12], p[9:5], p[9:7], p[4:0], p[4:2]};
    return {p[15:11], p[15:13], p[10:5], p[10:9], p[4:0], p[4:2]};
  endfunction
  task automatic lut_load(input logic [7:0] i, input logic [23:0] c);
    @(posedge clk);
    #1;
    {lut_wr, lut_index, lut_color} = {1'b1, i, c};
    @(posedge clk);
    #1;
    lut_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [19:0] a, input logic [7:0] e);
    host.read_byte(a, got, ok);
    chk_byte({7'h0, ok}, 8'h01);
    chk_byte(got, e);
  endtask
  task automatic fetch(input logic [18:0] a, input logic [2:0] b, input logic [23:0] e);
    @(posedge clk);
    #1;
    {pix_req, pix_addr, pix_bit} = {1'b1, a, b};
    @(posedge clk);
    #1;
    pix_req = 1'b0;
    @(posedge clk);
    #1;
    chk_byte({7'h0, dac_valid}, 8'h01);
    chk_rgb({dac_red, dac_green, dac_blue}, e);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_planar();
    for (int p = 0; p < 4; p++) begin
      d[p] = 8'h35 ^ (8'h4c * p[7:0]);
      plane_wr_mask = 4'h1 << p;
      host.write_byte(20'ha0010, d[p]);
    end
    plane_wr_mask = 4'h0;
    host.write_byte(20'ha0010, 8'hff);
    for (int p = 0; p < 4; p++) begin
      plane_rd_sel = p[1:0];
      rd_chk(20'ha0010, d[p]);
    end
    for (int i = 0; i < 16; i++) lut_load(i[7:0], pal(i[7:0]));
    for (int b = 0; b < 8; b += 7)
      fetch(19'h10, b[2:0], pal({4'h0, d[3][7-b], d[2][7-b], d[1][7-b], d[0][7-b]}));
  endtask
  task automatic t_window();
    plane_wr_mask = 4'h1;
    plane_rd_sel = 2'h0;
    host.write_byte(20'hb0010, 8'hff);
    host.write_byte(20'haffff, 8'hc3);
    rd_chk(20'haffff, 8'hc3);
    page_sel = 4'h1;
    host.write_byte(20'ha0010, 8'h5a);
    rd_chk(20'ha0010, 8'h5a);
    page_sel = 4'h0;
    rd_chk(20'ha0010, d[0]);
    host.read_byte(20'h90010, got, ok);
    chk_byte({7'h0, ok}, 8'h00);
  endtask
  task automatic t_direct(input logic [1:0] m, input logic [18:0] n, input logic [15:0] p);
    logic [19:0] b;
    b = {n, 1'b0};
    mode = m;
    page_sel = b[19:16];
    host.write_byte({4'ha, b[15:0]}, p[7:0]);
    host.write_byte({4'ha, b[15:1], 1'b1}, p[15:8]);
    rd_chk({4'ha, b[15:1], 1'b1}, p[15:8]);
    fetch(n, 3'h0, dc(m, p));
    page_sel = 4'h0;
  endtask
  task automatic t_index();
    mode = `DMP_MODE_INDEX;
    lut_load(8'hff, 24'h3c96e1);
    host.write_byte(20'ha0021, 8'h07);
    host.write_byte(20'ha0022, 8'hff);
    fetch(19'h21, 3'h0, pal(8'h07));
    fetch(19'h22, 3'h0, 24'h3c96e1);
  endtask
  initial begin
    #20000;
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge clk);
    #1;
    reset = 1'b0;
    t_planar();
    t_window();
    t_direct(`DMP_MODE_DC15, 19'h5, 16'hfa5c);
    t_direct(`DMP_MODE_DC16, 19'h6, 16'h8c3f);
    t_direct(`DMP_MODE_DC16, 19'h752ff, 16'h1234);
    t_index();
    end_of_test();
  end
endmodule // dmp_pixel_layout_test
